// >>> logic/ddsfs_device.sv
// Purpose: device end, serial word capture, tuning word choice and phase accumulator
// Assumes: link pins asynchronous to clk_sys, synchronised by two flops
// Notes:   word content and command decode are the user's business
`timescale 1ns/100ps
module ddsfs_device
	import ddsfs_pkg::*;
(
	input  wire logic                 clk_sys,
	input  wire logic                 srst,
	ddsfs_link_if.device              link,
	input  wire logic [ACC_BITS-1:0]  tuningWordA,
	input  wire logic [ACC_BITS-1:0]  tuningWordB,
	input  wire logic                 choiceFromBit,
	input  wire logic                 choiceBit,
	output logic [WORD_BITS-1:0]      rxWord,
	output logic                      rxValid,
	output logic                      activeChoice,
	output logic [ACC_BITS-1:0]       phaseAcc
);
	// synchroniser chains: stage 0 may go metastable, so only stage 1 ever reads it
	logic [2:0]           sclkSync;
	logic [1:0]           dataSync;
	logic [1:0]           frameSync;
	logic [1:0]           choiceSync;

	// word assembly state
	logic [WORD_BITS-1:0] shifter;
	logic [CNT_BITS-1:0]  bitCnt;

	// next values
	logic [WORD_BITS-1:0] next_shifter;
	logic [CNT_BITS-1:0]  next_bitCnt;
	logic [WORD_BITS-1:0] next_rxWord;
	logic                 next_rxValid;
	logic [ACC_BITS-1:0]  next_phaseAcc;
	logic                 next_activeChoice;

	// decoded conditions
	logic                 sclkFall;
	logic                 frameLow;
	logic                 wordDone;
	logic                 bitTaken;
	logic                 wordTaken;
	logic                 selChoice;
	logic [WORD_BITS-1:0] shiftedWord;
	logic [ACC_BITS-1:0]  stepWord;

	// true on a one to zero step between two settled samples
	function automatic logic ddsfsFell(
		input logic older,
		input logic newer
	);
		return older & ~newer;
	endfunction

	// appends one serial bit at the low end, so the first bit sent ends up as the msb
	function automatic logic [WORD_BITS-1:0] ddsfsShiftIn(
		input logic [WORD_BITS-1:0] word,
		input logic                 bitIn
	);
		return {word[WORD_BITS-2:0], bitIn};
	endfunction

	// the count stops at the last bit of a word
	function automatic logic ddsfsIsLast(
		input logic [CNT_BITS-1:0] count
	);
		return count == CNT_BITS'(WORD_BITS - 1);
	endfunction

	// one of two step words by a one bit choice
	function automatic logic [ACC_BITS-1:0] ddsfsPickWord(
		input logic                choice,
		input logic [ACC_BITS-1:0] firstWord,
		input logic [ACC_BITS-1:0] secondWord
	);
		return choice ? secondWord : firstWord;
	endfunction

	// edge detect reads stages one and two only
	assign sclkFall    = ddsfsFell(sclkSync[2], sclkSync[1]);
	assign frameLow    = ~frameSync[1];
	assign wordDone    = ddsfsIsLast(bitCnt);
	assign bitTaken    = frameLow & sclkFall;
	assign wordTaken   = bitTaken & wordDone;
	assign shiftedWord = ddsfsShiftIn(shifter, dataSync[1]);

	// the control bit overrides the pin; the host keeps the pin at ground meanwhile
	assign selChoice = choiceFromBit ? choiceBit : choiceSync[1];
	assign stepWord  = ddsfsPickWord(selChoice, tuningWordA, tuningWordB);

	// the word is handed over only on its last bit; partial words never reach rxWord
	assign next_shifter = bitTaken ? shiftedWord : shifter;
	assign next_rxWord  = wordTaken ? shiftedWord : rxWord;
	assign next_rxValid = wordTaken;

	// the accumulator wraps at its full width, which makes the step a binary fraction of the clock
	assign next_phaseAcc     = phaseAcc + stepWord;
	assign next_activeChoice = selChoice;

	// a high frame clears the count, so a cut word is dropped and each low frame starts fresh
	always_comb begin
		next_bitCnt = bitCnt;
		if (!frameLow)
			next_bitCnt = CNT_RESET;
		else if (wordTaken)
			next_bitCnt = CNT_RESET;
		else if (bitTaken)
			next_bitCnt = bitCnt + 1'b1;
	end

	// link clock rests high, so its chain resets high and no false fall follows reset
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			sclkSync <= SCLK_SYNC_RESET;
		end else begin
			sclkSync <= {sclkSync[1:0], link.serialClk};
		end
	end

	// data passes the same depth as the clock, so a sampled bit lines up with its falling edge
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			dataSync <= PIN_SYNC_RESET;
		end else begin
			dataSync <= {dataSync[0], link.serialDataIn};
		end
	end

	// frame idles high, so reset leaves the word count cleared
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			frameSync <= FRAME_SYNC_RESET;
		end else begin
			frameSync <= {frameSync[0], link.wordFrameSync};
		end
	end

	// two flops add latency; a pin that moves at a clock edge may switch one cycle late
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			choiceSync <= PIN_SYNC_RESET;
		end else begin
			choiceSync <= {choiceSync[0], link.tuningWordChoice};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			shifter <= WORD_RESET;
		end else begin
			shifter <= next_shifter;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			bitCnt <= CNT_RESET;
		end else begin
			bitCnt <= next_bitCnt;
		end
	end

	// holds the last complete word until the next one lands
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rxWord <= WORD_RESET;
		end else begin
			rxWord <= next_rxWord;
		end
	end

	// one cycle pulse with each new word
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rxValid <= FLAG_CLEAR;
		end else begin
			rxValid <= next_rxValid;
		end
	end

	// advances on every master clock, never gated
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			phaseAcc <= ACC_RESET;
		end else begin
			phaseAcc <= next_phaseAcc;
		end
	end

	// registered so the selection seen outside never glitches
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			activeChoice <= FLAG_CLEAR;
		end else begin
			activeChoice <= next_activeChoice;
		end
	end
endmodule

// >>> logic/ddsfs_pkg.sv
// Purpose: shared constants for the serial word loader and tuning word selector
// Assumes: one system clock, link clock sampled as data
// Notes:   widths fixed
package ddsfs_pkg;
	localparam int WORD_BITS    = 16;
	localparam int ACC_BITS     = 32;
	localparam int CNT_BITS     = 5;
	localparam int SCLK_HALF    = 5;            // host link clock half period in clk_sys cycles
	localparam int DIV_BITS     = 4;
	localparam logic [CNT_BITS-1:0] CNT_RESET = 5'h00;
	localparam logic [ACC_BITS-1:0] ACC_RESET = 32'h00000000;
	localparam logic [WORD_BITS-1:0] WORD_RESET = 16'h0000;
	localparam logic [2:0] SCLK_SYNC_RESET  = 3'h7;     // link clock idles high
	localparam logic [1:0] FRAME_SYNC_RESET = 2'h3;     // frame idles high
	localparam logic [1:0] PIN_SYNC_RESET   = 2'h0;
	localparam logic       FLAG_CLEAR       = 1'h0;
	localparam logic       FLAG_SET         = 1'h1;
	// gray order along idle, high, low, high ... low, done, idle
	typedef enum logic [1:0] {
		DDSFS_IDLE = 2'h0,
		DDSFS_HIGH = 2'h1,
		DDSFS_LOW  = 2'h3,
		DDSFS_DONE = 2'h2
	} ddsfs_host_type;
endpackage

// >>> logic/ddsfs_link_if.sv
// Purpose: three wire serial link plus tuning word choice pin
// Assumes: all signals driven by the host end
// Notes:   no clocking block
`timescale 1ns/100ps
interface ddsfs_link_if;
	logic serialClk;
	logic serialDataIn;
	logic wordFrameSync;
	logic tuningWordChoice;
	modport device (input serialClk, input serialDataIn, input wordFrameSync, input tuningWordChoice);
	modport host   (output serialClk, output serialDataIn, output wordFrameSync, output tuningWordChoice);
endinterface

// >>> logic/ddsfs_host.sv
// Purpose: host end, shifts one 16-bit word per request and drives the choice pin
// Assumes: link clock made here by a divider of clk_sys
// Notes:   data changes on rising link edge, device samples on falling
`timescale 1ns/100ps
module ddsfs_host
	import ddsfs_pkg::*;
(
	input  wire logic                 clk_sys,
	input  wire logic                 srst,
	input  wire logic                 sendValid,
	output logic                      sendReady,
	input  wire logic [WORD_BITS-1:0] sendWord,
	input  wire logic                 choiceLevel,
	ddsfs_link_if.host                link
);
	ddsfs_host_type state;
	logic [DIV_BITS-1:0]  div;
	logic [CNT_BITS-1:0]  bitCnt;
	logic [WORD_BITS-1:0] shifter;
	logic                 choice;
	logic                 idleSeen;
	wire halfTick = (div == DIV_BITS'(SCLK_HALF - 1));
	wire lastBit  = (bitCnt == CNT_BITS'(WORD_BITS - 1));

	// one idle cycle is forced between frames, so the frame stays high for two samples at least
	assign sendReady = (state == DDSFS_IDLE) & idleSeen;
	assign link.serialClk = (state != DDSFS_LOW);
	assign link.serialDataIn = shifter[WORD_BITS-1];
	assign link.wordFrameSync = (state == DDSFS_IDLE);
	assign link.tuningWordChoice = choice;

	// choice pin moves only on the divider's terminal count, where the link clock toggles or the frame ends, so never while idle
	always_ff @(posedge clk_sys) begin
		if (srst)
			choice <= 1'b0;
		else if (halfTick)
			choice <= choiceLevel;
	end

	always_ff @(posedge clk_sys) begin
		if (srst)
			idleSeen <= FLAG_SET;
		else
			idleSeen <= (state == DDSFS_IDLE);
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state   <= DDSFS_IDLE;
			div     <= '0;
			bitCnt  <= CNT_RESET;
			shifter <= WORD_RESET;
		end else begin
			div <= halfTick ? '0 : div + 1'b1;
			case (state)
				DDSFS_IDLE: begin
					div <= '0;
					if (sendValid && idleSeen) begin
						shifter <= sendWord;
						bitCnt  <= CNT_RESET;
						state   <= DDSFS_HIGH;
					end
				end
				DDSFS_HIGH: if (halfTick) state <= DDSFS_LOW;
				DDSFS_LOW: begin
					if (halfTick) begin
						if (lastBit) begin
							state <= DDSFS_DONE;
						end else begin
							shifter <= {shifter[WORD_BITS-2:0], 1'b0};
							bitCnt  <= bitCnt + 1'b1;
							state   <= DDSFS_HIGH;
						end
					end
				end
				DDSFS_DONE: if (halfTick) state <= DDSFS_IDLE;
				default: state <= DDSFS_IDLE;
			endcase
		end
	end
endmodule

// >>> sim/ddsfs_link_assertions.sv
// Purpose: link wire checks between host and device ends
// Assumes: host end drives every link pin
// Notes:   one clock domain
`timescale 1ns/100ps
module ddsfs_link_assertions (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic serialClk,
	input wire logic serialDataIn,
	input wire logic wordFrameSync,
	input wire logic tuningWordChoice
);
	logic [4:0] nFall;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	// falls are counted per frame, so a short frame shows at its end
	always_ff @(posedge clk_sys)
		nFall <= (srst || wordFrameSync) ? 5'h00 : nFall + 5'($fell(serialClk));
	chk_idle_high: assert property (wordFrameSync |-> serialClk) else $error("clock low outside frame");
	chk_frame_len: assert property ($fell(wordFrameSync) |-> ##164 !wordFrameSync ##1 wordFrameSync) else $error("frame length");
	chk_low_phase: assert property ($fell(serialClk) |-> !serialClk[*5] ##1 serialClk) else $error("low phase");
	chk_high_phase: assert property ($rose(serialClk) && !wordFrameSync |-> serialClk[*5]) else $error("high phase");
	chk_data_hold: assert property (!serialClk |-> $stable(serialDataIn)) else $error("data moved");
	chk_fall_framed: assert property ($fell(serialClk) |-> !wordFrameSync) else $error("fall unframed");
	chk_bit_count: assert property ($rose(wordFrameSync) |-> nFall == 5'h10) else $error("bit count");
	chk_frame_gap: assert property ($rose(wordFrameSync) |-> ##1 wordFrameSync) else $error("no gap");
	cover property ($rose(wordFrameSync));
	cover property ($rose(tuningWordChoice));
	cover property ($fell(tuningWordChoice));
	cover property ($rose(wordFrameSync) ##2 $fell(wordFrameSync));
endmodule

// >>> sim/tb_top.sv
// Purpose: both ends joined, words and choice compared with a model
// Assumes: host makes the link clock from clk_sys
// Notes:   random words from an lfsr seeded with 86
`timescale 1ns/100ps
module tb_top
	import ddsfs_pkg::*;
;
	logic        clk_sys = 1'b0, srst = 1'b1, sendValid = 1'b0, choiceLevel = 1'b0, fromBit = 1'b0, choiceBit = 1'b0;
	logic [15:0] sendWord = 16'h0000, rnd = 16'h0056, rxWord;
	logic [31:0] wordA = 32'h00000000, wordB = 32'h00000000, phaseAcc, accPrev;
	logic        sendReady, rxValid, activeChoice;
	int          nMismatch = 0, totalChecks = 0;
	logic [15:0] sentQ[$];
	ddsfs_link_if link ();
	always #4 clk_sys = ~clk_sys;
	ddsfs_host ddsfs_host_inst (.clk_sys(clk_sys), .srst(srst), .sendValid(sendValid), .sendReady(sendReady),
		.sendWord(sendWord), .choiceLevel(choiceLevel), .link(link.host));
	ddsfs_device ddsfs_device_inst (.clk_sys(clk_sys), .srst(srst), .link(link.device), .tuningWordA(wordA),
		.tuningWordB(wordB), .choiceFromBit(fromBit), .choiceBit(choiceBit), .rxWord(rxWord), .rxValid(rxValid),
		.activeChoice(activeChoice), .phaseAcc(phaseAcc));
	ddsfs_link_assertions ddsfs_link_assertions_inst (.clk_sys(clk_sys), .srst(srst), .serialClk(link.serialClk),
		.serialDataIn(link.serialDataIn), .wordFrameSync(link.wordFrameSync), .tuningWordChoice(link.tuningWordChoice));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
		totalChecks++;
		if (seen !== want) begin
			nMismatch++;
			$display("ERROR %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic closeOut;
		if (nMismatch == 0 && totalChecks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	function automatic logic [15:0] lfsrNext(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// each received word pairs with the oldest word sent, so a lost, extra or doubled word shows at once
	always @(negedge clk_sys) begin
		if (srst == 1'b0 && rxValid !== 1'b0) begin
			check("rxSpare", 32'(sentQ.size() == 0), 32'h00000000);
			if (sentQ.size() != 0)
				check("rxWord", {15'h0000, rxValid, rxWord}, {16'h0001, sentQ.pop_front()});
		end
	end
	task automatic sendOne(input logic [15:0] w);
		int k;
		for (k = 0; k < 400 && sendReady !== 1'b1; k++)
			@(negedge clk_sys);
		check("sendReady", {31'h00000000, sendReady}, 32'h00000001);
		sendValid = 1'b1;
		sendWord = w;
		sentQ.push_back(w);
		@(negedge clk_sys);
		sendValid = 1'b0;
	endtask
	task automatic drain;
		int k;
		for (k = 0; k < 400 && sentQ.size() != 0; k++)
			@(negedge clk_sys);
		check("rxPending", 32'(sentQ.size()), 32'h00000000);
	endtask
	initial begin
		#40000;
		nMismatch++;
		closeOut();
	end
	initial begin : main
		logic sel;
		repeat (2) @(negedge clk_sys);
		srst = 1'b0;
		for (int i = 0; i < 8; i++) begin
			rnd = lfsrNext(rnd);
			sel = 1'(i);
			wordA = {rnd, ~rnd};
			wordB = {~rnd, rnd};
			fromBit = 1'(i >> 1);
			choiceBit = sel;
			choiceLevel = fromBit ? 1'b0 : sel;
			sendOne((i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : rnd);
			if (i == 7)
				sendOne(~rnd);
			drain();
			repeat (4) @(negedge clk_sys);
			check("activeChoice", {31'h00000000, activeChoice}, {31'h00000000, sel});
			accPrev = phaseAcc;
			@(negedge clk_sys);
			check("phaseStep", phaseAcc - accPrev, sel ? wordB : wordA);
		end
		// second reset in mid run, then one more word to show the link recovers
		srst = 1'b1;
		repeat (2) @(negedge clk_sys);
		check("resetAcc", phaseAcc, 32'h00000000);
		check("resetFlags", {29'h00000000, rxValid, activeChoice, sendReady}, 32'h00000001);
		check("resetWord", {16'h0000, rxWord}, 32'h00000000);
		srst = 1'b0;
		rnd = lfsrNext(rnd);
		sendOne(rnd);
		drain();
		closeOut();
	end
endmodule
